// File: hdl/external_memory_controller.sv
// External memory controller: decode, arbitration, buffering, static timing, refresh
`timescale 1ns/1ps
module external_memory_controller
    import emc_pkg::*;
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      dyn_reset_i,
    input  wire logic [NUM_PORTS-1:0]      req_valid_i,
    input  wire mem_req_t [NUM_PORTS-1:0]  req_i,
    output logic      [NUM_PORTS-1:0]      req_ready_o,
    output logic                           rsp_valid_o,
    output logic [31:0]                    rsp_data_o,
    output logic [1:0]                     rsp_port_o,
    input  wire logic                      rsp_ready_i,
    input  wire static_timing_t            static_timing_i,
    input  wire static_width_t             static_width_i,
    input  wire dyn_kind_t                 dyn_kind_i,
    input  wire logic                      dyn_wide_i,
    input  wire logic [1:0]                dyn_rows_i,
    input  wire logic [15:0]               refresh_interval_i,
    input  wire logic                      self_refresh_req_i,
    input  wire logic                      power_save_i,
    input  wire logic                      ext_wait_i,
    input  wire logic [31:0]               mem_rdata_i,
    output logic                           dyn_chip_sel_a_o,
    output logic                           dyn_chip_sel_b_o,
    output logic [3:0]                     static_sel_o,
    output logic [31:0]                    mem_addr_o,
    output logic [31:0]                    mem_wdata_o,
    output logic                           mem_wdata_oe_o,
    output logic                           mem_oe_o,
    output logic                           mem_we_o,
    output logic [3:0]                     mem_be_o,
    output logic [1:0]                     mem_clock_enable_o,
    output logic                           mem_clock_out_o,
    output logic                           refresh_cmd_o,
    output logic                           self_refresh_ack_o,
    output logic                           cfg_error_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding
    function automatic logic [5:0] decode(input logic [31:0] a);
        logic [5:0] s;
        s = 6'h00;
        s[0] = (a >= DYN_A_LO) && (a <= DYN_A_HI);
        s[1] = (a >= DYN_B_LO) && (a <= DYN_B_HI);
        if ((a >= STAT_LO) && (a <= STAT_HI))
            s[2 + a[STAT_SEL_LSB +: 2]] = 1'b1;
        return s;
    endfunction

    // Ext wait pin comes from off-chip
    logic ext_wait_s1_r, ext_wait_s2_r;
    always_ff @(posedge sys_clk_i)
    begin
        ext_wait_s1_r <= ext_wait_i;
        ext_wait_s2_r <= ext_wait_s1_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Round-robin arbitration over three ports
    logic [1:0] last_r;
    logic [1:0] grant;
    logic       any_req;
    always_comb
    begin
        grant = last_r;
        any_req = 1'b0;
        for (int k = 1; k <= NUM_PORTS; k++)
        begin
            int p;
            p = (int'(last_r) + k) % NUM_PORTS;
            if (!any_req && req_valid_i[p])
            begin
                grant = p[1:0];
                any_req = 1'b1;
            end
        end
    end

    typedef enum {S_IDLE, S_SETUP, S_STROBE, S_EXTWAIT, S_TURN, S_REFRESH} state_t;
    state_t     state_r, state_nxt;
    mem_req_t   cur_r;
    logic [1:0] cur_port_r;
    logic [3:0] cnt_r;

    // Response buffer, two entries; it stalls the memory side when full
    logic [33:0] buf_mem [BUF_DEPTH];
    logic        wp_r, rp_r;
    logic [1:0]  cnt_buf_r;
    logic        buf_full, buf_push;
    assign buf_full = (cnt_buf_r == 2'(BUF_DEPTH));

    logic       refresh_due_r;
    logic       sr_active_r;
    logic [5:0] sel_dec;
    assign sel_dec = decode(req_i[grant].addr);
    wire        take = (state_r == S_IDLE) && any_req && !buf_full && !sr_active_r
                       && !refresh_due_r && (sel_dec != 6'h00);
    wire        drop = (state_r == S_IDLE) && any_req && (sel_dec == 6'h00);
    wire [5:0]  cur_sel = decode(cur_r.addr);
    wire        is_static = |cur_sel[5:2];
    wire [3:0]  strobe_len = cur_r.wr ? static_timing_i.wait_wr : static_timing_i.wait_rd;

    ////////////////////////////////////////////////////////////////////////
    // Refresh and self-refresh, in the dynamic reset domain
    logic [15:0] refi_cnt_r;
    logic        dyn_busy;
    assign dyn_busy = (state_r != S_IDLE) && (state_r != S_REFRESH);
    always_ff @(posedge sys_clk_i)
    begin
        if (dyn_reset_i)
        begin
            refi_cnt_r    <= REFI_ZERO;
            refresh_due_r <= 1'b0;
            sr_active_r   <= 1'b0;
        end
        else
        begin
            if (!dyn_busy)
                sr_active_r <= self_refresh_req_i;
            if (sr_active_r || refresh_interval_i == REFI_ZERO)
                refi_cnt_r <= REFI_ZERO;
            else if (refi_cnt_r >= refresh_interval_i)
                refi_cnt_r <= REFI_ZERO;
            else
                refi_cnt_r <= refi_cnt_r + 16'h0001;
            if (!sr_active_r && refresh_interval_i != REFI_ZERO
                && refi_cnt_r >= refresh_interval_i)
                refresh_due_r <= 1'b1;
            else if (state_r == S_REFRESH)
                refresh_due_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (refresh_due_r && !sr_active_r)
                    state_nxt = S_REFRESH;
                else if (take)
                    state_nxt = S_SETUP;
            S_SETUP:
                if (!is_static || cnt_r == WAIT_ZERO)
                    state_nxt = S_STROBE;
            S_STROBE:
                if (cnt_r == WAIT_ZERO)
                    state_nxt = (is_static && static_timing_i.ext_wait_en)
                                ? S_EXTWAIT : S_TURN;
            S_EXTWAIT:
                if (!ext_wait_s2_r)
                    state_nxt = S_TURN;
            S_TURN:
                if (cnt_r == WAIT_ZERO)
                    state_nxt = S_IDLE;
            S_REFRESH:
                state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    // Pins lag the state by one register, so read data is captured a cycle after strobe end
    logic strobe_done;
    logic push_pend_r;
    assign strobe_done = cur_r.wr ? 1'b0 :
                         ((state_r == S_STROBE && cnt_r == WAIT_ZERO
                           && !(is_static && static_timing_i.ext_wait_en))
                          || (state_r == S_EXTWAIT && !ext_wait_s2_r));
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            push_pend_r <= 1'b0;
        else
            push_pend_r <= strobe_done;
    end
    assign buf_push = push_pend_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_r    <= S_IDLE;
            last_r     <= 2'h0;
            cnt_r      <= WAIT_ZERO;
            cur_r      <= '0;
            cur_port_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            if (take)
            begin
                cur_r      <= req_i[grant];
                cur_port_r <= grant;
                last_r     <= grant;
                cnt_r      <= static_timing_i.oe_dly;
                if (req_i[grant].wr)
                    cnt_r <= static_timing_i.we_dly;
            end
            else if (state_r != state_nxt)
            begin
                case (state_nxt)
                    S_STROBE: cnt_r <= is_static ? strobe_len : WAIT_ZERO;
                    S_TURN:   cnt_r <= is_static ? static_timing_i.turn : WAIT_ZERO;
                    default:  cnt_r <= WAIT_ZERO;
                endcase
            end
            else if (cnt_r != WAIT_ZERO)
                cnt_r <= cnt_r - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered
    wire active = (state_r == S_SETUP) || (state_r == S_STROBE) || (state_r == S_EXTWAIT);
    wire strobe = (state_r == S_STROBE) || (state_r == S_EXTWAIT);
    // Page reads: with page_en, OE is also kept in setup; it still drops in turnaround and idle between reads
    wire oe_n = active && !cur_r.wr && (strobe || static_timing_i.page_en);
    wire [3:0] be_w = (static_width_i == SW_8)  ? 4'h1 :
                      (static_width_i == SW_16) ? 4'h3 : 4'hF;
    // DDR only supports a 16-bit bus; a wide DDR setting is flagged
    wire cfg_bad = (dyn_kind_i == DK_DDR && dyn_wide_i) || (dyn_rows_i == 2'h3);

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            dyn_chip_sel_a_o <= 1'b0;
            dyn_chip_sel_b_o <= 1'b0;
            static_sel_o     <= 4'h0;
            mem_addr_o       <= 32'h0000_0000;
            mem_wdata_o      <= 32'h0000_0000;
            mem_wdata_oe_o   <= 1'b0;
            mem_oe_o         <= 1'b0;
            mem_we_o         <= 1'b0;
            mem_be_o         <= 4'h0;
            req_ready_o      <= 3'h0;
            cfg_error_o      <= 1'b0;
        end
        else
        begin
            dyn_chip_sel_a_o <= active && cur_sel[0];
            dyn_chip_sel_b_o <= active && cur_sel[1];
            static_sel_o     <= active ? cur_sel[5:2] : 4'h0;
            mem_addr_o       <= cur_r.addr;
            mem_wdata_o      <= cur_r.wdata;
            mem_wdata_oe_o   <= active && cur_r.wr;
            mem_oe_o         <= oe_n;
            mem_we_o         <= strobe && cur_r.wr;
            mem_be_o         <= cur_r.be & (is_static ? be_w :
                                (dyn_wide_i && dyn_kind_i == DK_SDR) ? 4'hF : 4'h3);
            for (int i = 0; i < NUM_PORTS; i++)
                req_ready_o[i] <= (take || drop) && (grant == i[1:0]);
            cfg_error_o      <= cfg_bad;
        end
    end

    // Dynamic-domain pins survive a soft reset
    always_ff @(posedge sys_clk_i)
    begin
        if (dyn_reset_i)
        begin
            mem_clock_enable_o <= 2'h0;
            mem_clock_out_o    <= 1'b0;
            refresh_cmd_o      <= 1'b0;
            self_refresh_ack_o <= 1'b0;
        end
        else
        begin
            mem_clock_enable_o[0] <= !sr_active_r && !(power_save_i && !active);
            mem_clock_enable_o[1] <= !sr_active_r && !(power_save_i && !active);
            mem_clock_out_o       <= !mem_clock_out_o && !(sr_active_r ||
                                     (power_save_i && !active));
            refresh_cmd_o         <= (state_r == S_REFRESH);
            self_refresh_ack_o    <= sr_active_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data buffer
    always_ff @(posedge sys_clk_i)
    begin
        if (buf_push)
            buf_mem[wp_r] <= {cur_port_r, mem_rdata_i};
        if (reset_i)
        begin
            wp_r        <= 1'b0;
            rp_r        <= 1'b0;
            cnt_buf_r   <= 2'h0;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= 32'h0000_0000;
            rsp_port_o  <= 2'h0;
        end
        else
        begin
            if (buf_push)
                wp_r <= ~wp_r;
            if ((!rsp_valid_o || rsp_ready_i) && cnt_buf_r != 2'h0)
            begin
                rsp_valid_o <= 1'b1;
                {rsp_port_o, rsp_data_o} <= buf_mem[rp_r];
                rp_r <= ~rp_r;
                cnt_buf_r <= cnt_buf_r - 2'h1 + {1'b0, buf_push};
            end
            else
            begin
                if (rsp_ready_i)
                    rsp_valid_o <= 1'b0;
                cnt_buf_r <= cnt_buf_r + {1'b0, buf_push};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_no_sel_outside;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state_r == S_SETUP && cur_sel == 6'h00) |=> !dyn_chip_sel_a_o && static_sel_o == 4'h0;
    endproperty
    a_no_sel_outside: assert property (p_no_sel_outside) else $error("select outside windows");
    property p_dyn_a;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state_r == S_SETUP && cur_sel[0]) |=> dyn_chip_sel_a_o;
    endproperty
    a_dyn_a: assert property (p_dyn_a) else $error("dyn select a missing");
    property p_dyn_b;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state_r == S_SETUP && cur_sel[1]) |=> dyn_chip_sel_b_o && !dyn_chip_sel_a_o;
    endproperty
    a_dyn_b: assert property (p_dyn_b) else $error("dyn select b wrong");
    property p_static_onehot;
        @(posedge sys_clk_i) disable iff (reset_i) $onehot0(static_sel_o);
    endproperty
    a_static_onehot: assert property (p_static_onehot) else $error("static selects overlap");
    property p_refresh_pulse;
        @(posedge sys_clk_i) disable iff (dyn_reset_i || reset_i)
        refresh_cmd_o |=> !refresh_cmd_o;
    endproperty
    a_refresh_pulse: assert property (p_refresh_pulse) else $error("refresh too long");
    property p_no_refresh_sr;
        @(posedge sys_clk_i) disable iff (dyn_reset_i || reset_i)
        sr_active_r && $past(sr_active_r) |-> ##1 !refresh_cmd_o;
    endproperty
    a_no_refresh_sr: assert property (p_no_refresh_sr) else $error("refresh in self-refresh");
    property p_cke_sr;
        @(posedge sys_clk_i) disable iff (dyn_reset_i)
        sr_active_r |=> mem_clock_enable_o == 2'h0;
    endproperty
    a_cke_sr: assert property (p_cke_sr) else $error("clock enable in self-refresh");
    property p_one_grant;
        @(posedge sys_clk_i) disable iff (reset_i) $onehot0(req_ready_o);
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("several ports granted");
    c_static: cover property (@(posedge sys_clk_i) |static_sel_o);
    c_refresh: cover property (@(posedge sys_clk_i) refresh_cmd_o);
    c_full: cover property (@(posedge sys_clk_i) buf_full);

endmodule // external_memory_controller

// File: hdl/emc_pkg.sv
// Package: constants and carriers for the external memory controller
package emc_pkg;
    localparam logic [31:0] DYN_A_LO      = 32'h8000_0000;
    localparam logic [31:0] DYN_A_HI      = 32'h9FFF_FFFF;
    localparam logic [31:0] DYN_B_LO      = 32'hA000_0000;
    localparam logic [31:0] DYN_B_HI      = 32'hBFFF_FFFF;
    localparam logic [31:0] STAT_LO       = 32'hE000_0000;
    localparam logic [31:0] STAT_HI       = 32'hE3FF_FFFF;
    localparam int          STAT_SEL_LSB  = 24;
    localparam int          NUM_PORTS     = 3;
    localparam int          BUF_DEPTH     = 2;
    localparam logic [3:0]  WAIT_ZERO     = 4'h0;
    localparam logic [15:0] REFI_ZERO     = 16'h0000;

    // Static device widths
    typedef enum logic [1:0] {SW_8, SW_16, SW_32} static_width_t;
    // Dynamic memory kinds
    typedef enum logic {DK_SDR, DK_DDR} dyn_kind_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        wr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } mem_req_t;

    typedef struct packed {
        logic [3:0] wait_rd;
        logic [3:0] wait_wr;
        logic [3:0] oe_dly;
        logic [3:0] we_dly;
        logic [3:0] turn;
        logic       page_en;
        logic       ext_wait_en;
    } static_timing_t;
endpackage

// File: tb/mem_model.sv
// Behavioural external memory shared by all dynamic and static selects
`timescale 1ns/1ps
module mem_model
    import emc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sel_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        oe_i,
    input  wire logic        we_i,
    output logic [31:0]      rdata_o
);
    logic [31:0] mem [256];
    logic [31:0] last_r;
    logic        drive;

    initial last_r = 32'h0000_0000;
    assign drive   = sel_i && oe_i;
    // Undriven bus shows the inverse of its last value so stale data cannot pass
    assign rdata_o = drive ? mem[addr_i[9:2]] : ~last_r;

    always @(posedge sys_clk_i)
    begin
        if (sel_i && we_i)
            mem[addr_i[9:2]] <= wdata_i;
        last_r <= rdata_o;
    end
endmodule // mem_model

// File: tb/tb_top.sv
// Self-checking testbench for the external memory controller
`timescale 1ns/1ps
module tb_top
    import emc_pkg::*;
;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, dyn_reset_i = 1'b1, rsp_ready_i = 1'b1;
    logic [NUM_PORTS-1:0] req_valid_i = '0, req_ready_o;
    mem_req_t [NUM_PORTS-1:0] req_i = '0;
    static_timing_t static_timing_i = '0;
    static_width_t static_width_i = SW_32;
    dyn_kind_t dyn_kind_i = DK_SDR;
    logic dyn_wide_i = 1'b1, self_refresh_req_i = 1'b0, power_save_i = 1'b0, ext_wait_i = 1'b0;
    logic [1:0] dyn_rows_i = 2'h0, rsp_port_o, mem_clock_enable_o;
    logic [15:0] refresh_interval_i = 16'h0000;
    logic [31:0] mem_rdata_i, rsp_data_o, mem_addr_o, mem_wdata_o;
    logic [3:0] static_sel_o, mem_be_o;
    logic rsp_valid_o, dyn_chip_sel_a_o, dyn_chip_sel_b_o, mem_wdata_oe_o, mem_oe_o, mem_we_o;
    logic mem_clock_out_o, refresh_cmd_o, self_refresh_ack_o, cfg_error_o;
    logic [5:0] seen_sel = '0;
    logic clk_out_prev = 1'b0;
    logic [31:0] rsp_q [$];
    int failures = 0, comparisons = 0, cycles = 0, oe_cnt = 0, ref_cnt = 0, tog = 0, n, c0;
    logic [31:0] dec_addr [12] = '{32'h8000_0000, 32'h9FFF_FFFC, 32'hA000_0000, 32'hBFFF_FFFC,
        32'hE000_0000, 32'hE0FF_FFFC, 32'hE100_0000, 32'hE2FF_FFFC, 32'hE3FF_FFFC,
        32'h7FFF_FFFC, 32'hC000_0000, 32'hE400_0000};
    logic [5:0] dec_sel [12] = '{6'h20, 6'h20, 6'h10, 6'h10, 6'h01, 6'h01, 6'h02, 6'h04,
        6'h08, 6'h00, 6'h00, 6'h00};

    external_memory_controller DUT (.*);
    mem_model mem (.sys_clk_i(sys_clk_i),
        .sel_i(dyn_chip_sel_a_o | dyn_chip_sel_b_o | (|static_sel_o)), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .oe_i(mem_oe_o), .we_i(mem_we_o), .rdata_o(mem_rdata_i));

    always #12.5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i)
    begin
        seen_sel = seen_sel | {dyn_chip_sel_a_o, dyn_chip_sel_b_o, static_sel_o};
        oe_cnt += int'(mem_oe_o);
        ref_cnt += int'(refresh_cmd_o);
        tog += int'(mem_clock_out_o !== clk_out_prev);
        clk_out_prev = mem_clock_out_o;
        if (rsp_valid_o === 1'b1 && rsp_ready_i)
            rsp_q.push_back(rsp_data_o);
        cycles++;
        // Ceiling well above the fewer than two thousand cycles the sequence needs
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        comparisons++;
        if (act !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hold valid and request until the edge where ready is seen high
    task automatic wait_ready(input int p);
        int k;
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end while (req_ready_o[p] !== 1'b1 && k < 200);
        req_valid_i[p] <= 1'b0;
        chk(32'(k < 200), 32'h1);
    endtask

    task automatic access(input int p, input logic [31:0] a, input logic w, input logic [31:0] d);
        req_i[p] <= {a, w, d, 4'hF};
        req_valid_i[p] <= 1'b1;
        wait_ready(p);
        repeat (20) @(posedge sys_clk_i);
    endtask

    task automatic rd(input int p, input logic [31:0] a, input logic [31:0] exp);
        int k;
        k = 0;
        access(p, a, 1'b0, 32'h0);
        while (rsp_q.size() == 0 && k < 100)
        begin
            @(posedge sys_clk_i);
            k++;
        end
        chk(rsp_q.size() != 0 ? rsp_q.pop_front() : ~exp, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        dyn_reset_i <= 1'b0;
        @(posedge sys_clk_i);
        // Both edges of the dynamic windows and static select 0, one edge of static selects 1 to 3, plus addresses outside
        for (int i = 0; i < 12; i++)
        begin
            seen_sel = '0;
            access(0, dec_addr[i], 1'b1, 32'h5A00_0000 | i);
            chk(32'(seen_sel), 32'(dec_sel[i]));
            if (dec_sel[i] != 0)
                rd(1, dec_addr[i], 32'h5A00_0000 | i);
            else
            begin
                access(1, dec_addr[i], 1'b0, 32'h0);
                chk(32'(rsp_q.size()), 32'h0);
            end
        end
        // All three ports request in the same cycle
        req_i[0] <= {32'hE000_0010, 1'b1, 32'h0000_0001, 4'hF};
        req_i[1] <= {32'h8000_0020, 1'b1, 32'h0000_0002, 4'hF};
        req_i[2] <= {32'hA000_0030, 1'b1, 32'h0000_0003, 4'hF};
        req_valid_i <= 3'h7;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
            req_valid_i <= req_valid_i & ~req_ready_o;
        end while ((req_valid_i & ~req_ready_o) != 3'h0 && n < 200);
        chk(32'(n < 200), 32'h1);
        repeat (20) @(posedge sys_clk_i);
        rd(2, 32'hE000_0010, 32'h1);
        rd(0, 32'h8000_0020, 32'h2);
        rd(1, 32'hA000_0030, 32'h3);
        // Receiver stalls: output stage plus two buffer entries fill, a fourth read must wait
        rsp_ready_i <= 1'b0;
        access(0, 32'h8000_0020, 1'b0, 32'h0);
        access(1, 32'hE000_0010, 1'b0, 32'h0);
        access(2, 32'hA000_0030, 1'b0, 32'h0);
        req_i[0] <= {32'h8000_0020, 1'b0, 32'h0, 4'hF};
        req_valid_i[0] <= 1'b1;
        n = 0;
        repeat (40) @(posedge sys_clk_i) n += int'(req_ready_o[0] === 1'b1);
        chk(32'(n), 32'h0);
        rsp_ready_i <= 1'b1;
        wait_ready(0);
        repeat (30) @(posedge sys_clk_i);
        chk(32'(rsp_q.size()), 32'h4);
        for (int i = 0; i < 4 && rsp_q.size() != 0; i++)
            chk(rsp_q.pop_front(), 32'(i == 1 ? 1 : i == 2 ? 3 : 2));
        // Read strobe grows by exactly the wait states, then by an extended wait
        oe_cnt = 0;
        rd(0, 32'hE000_0010, 32'h1);
        c0 = oe_cnt;
        static_timing_i.wait_rd <= 4'h4;
        oe_cnt = 0;
        rd(0, 32'hE000_0010, 32'h1);
        chk(32'(oe_cnt - c0), 32'h4);
        static_timing_i <= static_timing_t'(18'h00001);
        ext_wait_i <= 1'b1;
        fork
            begin
                repeat (30) @(posedge sys_clk_i);
                ext_wait_i <= 1'b0;
            end
        join_none
        oe_cnt = 0;
        rd(0, 32'hE000_0010, 32'h1);
        chk(32'(oe_cnt >= 25), 32'h1);
        static_timing_i <= '0;
        // Refresh runs at a set interval and stops at zero or in self-refresh
        refresh_interval_i <= 16'h0010;
        ref_cnt = 0;
        repeat (200) @(posedge sys_clk_i);
        chk(32'(ref_cnt != 0), 32'h1);
        self_refresh_req_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end while (self_refresh_ack_o !== 1'b1 && n < 200);
        chk(32'(self_refresh_ack_o), 32'h1);
        reset_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        ref_cnt = 0;
        repeat (100) @(posedge sys_clk_i);
        chk(32'(ref_cnt), 32'h0);
        chk(32'(self_refresh_ack_o), 32'h1);
        chk(32'(mem_clock_enable_o), 32'h0);
        self_refresh_req_i <= 1'b0;
        repeat (100) @(posedge sys_clk_i);
        chk(32'(self_refresh_ack_o), 32'h0);
        chk(32'(mem_clock_enable_o != 2'h0), 32'h1);
        refresh_interval_i <= 16'h0000;
        repeat (2) @(posedge sys_clk_i);
        ref_cnt = 0;
        repeat (100) @(posedge sys_clk_i);
        chk(32'(ref_cnt), 32'h0);
        // Memory clock stops while power saving and runs again once it ends
        power_save_i <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        tog = 0;
        repeat (16) @(posedge sys_clk_i);
        chk(32'(tog), 32'h0);
        power_save_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        tog = 0;
        repeat (16) @(posedge sys_clk_i);
        chk(32'(tog != 0), 32'h1);
        // Dynamic configurations: wide DDR is refused, once with rows 0 and once with the unknown row size
        for (int i = 0; i < 6; i++)
        begin
            dyn_kind_i <= dyn_kind_t'(i / 3);
            dyn_wide_i <= 1'(i % 2);
            dyn_rows_i <= 2'(i % 3 + (i == 5 ? 1 : 0));
            repeat (3) @(posedge sys_clk_i);
            chk(32'(cfg_error_o), 32'(i == 3 || i == 5));
        end
        stop_test();
    end
endmodule // tb_top
